/* File: src/mpd_pkg.sv */
// shared constants and types for the motion parameter command decoder
package mpd_pkg;
  // instruction numbers
  localparam logic [7:0] MOVE_TO_POSITION_CMD = 8'h04;
  localparam logic [7:0] SET_AXIS_PARAM_CMD = 8'h05;
  localparam logic [7:0] GET_AXIS_PARAM_CMD = 8'h06;
  localparam logic [7:0] SET_GLOBAL_PARAM_CMD = 8'h09;
  localparam logic [7:0] GET_GLOBAL_PARAM_CMD = 8'h0A;
  // move type codes
  localparam logic [7:0] RELATIVE_MOVE_TYPE = 8'h01;
  localparam logic [7:0] STORED_COORDINATE_TYPE = 8'h02;
  // axis parameter numbers
  localparam int AP_TARGET_POS = 0;
  localparam int AP_ACTUAL_POS = 1;
  localparam int AP_MAX_SPEED = 4;
  // global parameter holding the bus address, bank 0
  localparam int GP_BUS_ADDR = 66;
  localparam logic [31:0] BUS_ADDR_RST = 32'h00000001;
  // reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  // frame length in bytes
  localparam logic [3:0] FRAME_LEN = 4'h9;
  // apb register byte offsets
  localparam logic [7:0] REG_FRAME = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REPLY = 8'h0C;
  localparam logic [7:0] REG_ACCU = 8'h10;
  localparam logic [7:0] REG_WP_IDX = 8'h14;
  localparam logic [7:0] REG_WP_DATA = 8'h18;
  // control and status bit positions
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_RESYNC_BIT = 1;
  localparam int STAT_VLD_BIT = 0;
  localparam int STAT_CODE_LSB = 8;
  // frame assembler state
  typedef struct packed {
    logic [3:0] cnt;
    logic [8:0][7:0] bytes;
    logic [7:0] sum;
    logic stb;
    logic ok;
  } mpd_fa_state_t;
  // bank number to slot: {valid, slot}
  function automatic logic [2:0] mpd_bank_slot(input logic [7:0] bank);
    case (bank)
      8'h00: mpd_bank_slot = 3'h4;
      8'h02: mpd_bank_slot = 3'h5;
      8'h03: mpd_bank_slot = 3'h6;
      default: mpd_bank_slot = 3'h0;
    endcase
  endfunction
endpackage

/* File: src/mpd_frame_asm.sv */
// collects nine-byte command frames and checks their checksum
`timescale 1ns/1ps
`default_nettype none
module mpd_frame_asm (
  input wire logic clk, // module clock
  input wire logic rst_n, // async reset, active low
  input wire logic byte_stb, // one frame byte offered
  input wire logic [7:0] byte_in, // frame byte
  input wire logic resync, // drop partial frame
  output logic frame_stb, // whole frame ready, one cycle
  output logic [8:0][7:0] frame_bytes, // frame, byte 0 first
  output logic sum_ok // checksum matched
);
  mpd_pkg::mpd_fa_state_t st_reg; // registered state
  mpd_pkg::mpd_fa_state_t st_next; // next state

  // byte collection and running sum
  always_comb begin
    st_next = st_reg;
    st_next.stb = 1'b0;
    if (resync) begin
      // restart at byte 0
      st_next.cnt = 4'h0;
      st_next.sum = 8'h00;
    end else if (byte_stb) begin
      st_next.bytes[st_reg.cnt] = byte_in;
      if (st_reg.cnt == mpd_pkg::FRAME_LEN - 4'h1) begin
        // last byte is the checksum of the eight before it
        st_next.stb = 1'b1;
        st_next.ok = (byte_in == st_reg.sum);
        st_next.cnt = 4'h0;
        st_next.sum = 8'h00;
      end else begin
        // low eight bits of the sum only
        st_next.sum = st_reg.sum + byte_in;
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign frame_stb = st_reg.stb;
  assign frame_bytes = st_reg.bytes;
  assign sum_ok = st_reg.ok;
endmodule
`default_nettype wire

/* File: src/mpd_cmd_decoder.sv */
// command frame decoder and parameter store with apb access
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mpd_cmd_decoder #(
  parameter int NM = 3, // number of motors
  parameter int NA = 16, // axis parameters per motor
  parameter int NG = 128, // global parameters per bank
  parameter int NW = 21 // stored waypoints
) (
  input wire logic SYS_CLK, // module clock, 25 MHz
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  output logic [NM-1:0][31:0] TARGET_POS, // target position per motor
  output logic [NM-1:0][31:0] MAX_SPEED, // max speed per motor, pps
  output logic [NM-1:0] MOVE_STB, // new target pulse per motor
  output logic NV_SAVE_STB, // save request pulse
  output logic [7:0] NV_SAVE_IDX, // bank 0 parameter number
  output logic [31:0] NV_SAVE_DATA, // value to save
  output logic [7:0] BUS_ADDR // current bus address
);
  localparam int MW = (NM > 1) ? $clog2(NM) : 1; // motor index width
  localparam int AW = $clog2(NA); // axis parameter index width
  localparam int GW = $clog2(NG); // global parameter index width
  localparam int WW = $clog2(NW); // waypoint index width

  // all state of the block
  typedef struct packed {
    logic [NM-1:0][NA-1:0][31:0] axis; // axis parameters
    logic [2:0][NG-1:0][31:0] glob; // banks 0, 2, 3
    logic [NW-1:0][31:0] wp; // stored waypoints
    logic [NW-1:0] wp_def; // waypoint defined flags
    logic [WW-1:0] wp_idx; // waypoint access index
    logic [31:0] accu; // accumulator
    logic [31:0] reply_val; // reply value
    logic [7:0] reply_st; // reply status
    logic reply_vld; // reply pending
    logic prog_mode; // frames come from stored program
    logic [31:0] prdata; // apb read data
    logic [NM-1:0] move_stb; // move pulses
    logic nv_stb; // save pulse
    logic [7:0] nv_idx; // save index
    logic [31:0] nv_data; // save value
  } mpd_core_state_t;

  mpd_core_state_t st_reg; // registered state
  mpd_core_state_t st_next; // next state

  logic wr_en; // apb write completes
  logic fa_stb; // frame ready
  logic [8:0][7:0] fa_bytes; // frame bytes
  logic fa_sum_ok; // checksum good
  logic [7:0] bus_addr; // address we answer to
  logic [7:0] f_addr; // frame target address
  logic [7:0] f_ins; // frame instruction
  logic [7:0] f_type; // frame type byte
  logic [7:0] f_mb; // frame motor or bank
  logic [31:0] f_val; // frame value
  logic [MW-1:0] f_m; // motor index
  logic [2:0] f_bank; // bank slot with valid
  logic addressed; // frame is for us
  logic go; // frame for us and checksum good
  logic motor_ok; // motor in range
  logic ax_ok; // axis parameter in range
  logic gp_ok; // global parameter and bank ok
  logic wp_ok; // waypoint in range and defined
  logic [31:0] rel_sum; // actual position plus offset
  logic [31:0] wp_sel; // selected waypoint
  logic [31:0] rd_val; // parameter read value
  logic [31:0] rd_mux; // apb read mux
  logic mapped; // apb address decodes

  // apb handshake, always zero wait
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // frame assembly off the frame byte register
  mpd_frame_asm u_fa (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .byte_stb(wr_en && (PADDR == mpd_pkg::REG_FRAME)),
    .byte_in(PWDATA[7:0]),
    .resync(wr_en && (PADDR == mpd_pkg::REG_CTRL) && PWDATA[mpd_pkg::CTRL_RESYNC_BIT]),
    .frame_stb(fa_stb),
    .frame_bytes(fa_bytes),
    .sum_ok(fa_sum_ok)
  );

  // frame fields
  assign bus_addr = st_reg.glob[0][mpd_pkg::GP_BUS_ADDR][7:0];
  assign f_addr = fa_bytes[0];
  assign f_ins = fa_bytes[1];
  assign f_type = fa_bytes[2];
  assign f_mb = fa_bytes[3];
  assign f_val = {fa_bytes[4], fa_bytes[5], fa_bytes[6], fa_bytes[7]};
  assign f_m = f_mb[MW-1:0];
  assign f_bank = mpd_pkg::mpd_bank_slot(f_mb);
  assign addressed = fa_stb && (f_addr == bus_addr);
  assign go = addressed && fa_sum_ok;
  assign motor_ok = f_mb < 8'(NM);
  assign ax_ok = f_type < 8'(NA);
  assign gp_ok = f_bank[2] && (f_type < 8'(NG));

  // operand lookups
  always_comb begin
    rel_sum = 32'h00000000;
    wp_sel = 32'h00000000;
    wp_ok = 1'b0;
    rd_val = 32'h00000000;
    if (motor_ok) begin
      // two's complement add, negative offset moves back
      rel_sum = st_reg.axis[f_m][mpd_pkg::AP_ACTUAL_POS] + f_val;
    end
    if (f_val < 32'(NW)) begin
      // waypoint must have been defined first
      wp_ok = st_reg.wp_def[f_val[WW-1:0]];
      wp_sel = st_reg.wp[f_val[WW-1:0]];
    end
    if (f_ins == mpd_pkg::GET_AXIS_PARAM_CMD && motor_ok && ax_ok) begin
      // parameter 1 holds the actual position
      rd_val = st_reg.axis[f_m][f_type[AW-1:0]];
    end else if (f_ins == mpd_pkg::GET_GLOBAL_PARAM_CMD && gp_ok) begin
      rd_val = st_reg.glob[f_bank[1:0]][f_type[GW-1:0]];
    end
  end

  // apb read decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (PADDR)
      mpd_pkg::REG_FRAME: rd_mux = 32'h00000000; // write only
      mpd_pkg::REG_CTRL: rd_mux[mpd_pkg::CTRL_PROG_BIT] = st_reg.prog_mode;
      mpd_pkg::REG_STATUS: begin
        rd_mux[mpd_pkg::STAT_VLD_BIT] = st_reg.reply_vld;
        rd_mux[mpd_pkg::STAT_CODE_LSB +: 8] = st_reg.reply_st;
      end
      mpd_pkg::REG_REPLY: rd_mux = st_reg.reply_val;
      mpd_pkg::REG_ACCU: rd_mux = st_reg.accu;
      mpd_pkg::REG_WP_IDX: rd_mux[WW-1:0] = st_reg.wp_idx;
      mpd_pkg::REG_WP_DATA: begin
        if (st_reg.wp_idx < WW'(NW)) begin
          rd_mux = st_reg.wp[st_reg.wp_idx];
        end
      end
      default: mapped = 1'b0; // unmapped reads zero
    endcase
  end

  // next state: apb writes first, frame execution after
  always_comb begin
    st_next = st_reg;
    st_next.move_stb = '0;
    st_next.nv_stb = 1'b0;
    // read data caught in the setup cycle
    if (PSEL && !PENABLE && !PWRITE) begin
      st_next.prdata = rd_mux;
    end
    // register writes
    if (wr_en) begin
      case (PADDR)
        mpd_pkg::REG_CTRL: st_next.prog_mode = PWDATA[mpd_pkg::CTRL_PROG_BIT];
        mpd_pkg::REG_STATUS: begin
          // write one clears reply pending
          if (PWDATA[mpd_pkg::STAT_VLD_BIT]) begin
            st_next.reply_vld = 1'b0;
          end
        end
        mpd_pkg::REG_WP_IDX: st_next.wp_idx = PWDATA[WW-1:0];
        mpd_pkg::REG_WP_DATA: begin
          // defines a waypoint for later moves
          if (st_reg.wp_idx < WW'(NW)) begin
            st_next.wp[st_reg.wp_idx] = PWDATA;
            st_next.wp_def[st_reg.wp_idx] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // frame execution; reply set wins over clear
    if (addressed) begin
      st_next.reply_vld = 1'b1;
      st_next.reply_val = 32'h00000000;
      st_next.reply_st = mpd_pkg::ST_OK;
      if (!fa_sum_ok) begin
        // bad checksum, nothing executed
        st_next.reply_st = mpd_pkg::ST_BAD_SUM;
      end else begin
        case (f_ins)
          mpd_pkg::MOVE_TO_POSITION_CMD: begin
            if (!motor_ok) begin
              st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
            end else if (f_type == mpd_pkg::RELATIVE_MOVE_TYPE) begin
              // offset from actual position
              st_next.axis[f_m][mpd_pkg::AP_TARGET_POS] = rel_sum;
              st_next.move_stb[f_m] = 1'b1;
            end else if (f_type == mpd_pkg::STORED_COORDINATE_TYPE) begin
              // value is a waypoint index
              if (wp_ok) begin
                st_next.axis[f_m][mpd_pkg::AP_TARGET_POS] = wp_sel;
                st_next.move_stb[f_m] = 1'b1;
              end else begin
                st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
              end
            end else begin
              st_next.reply_st = mpd_pkg::ST_BAD_TYPE;
            end
          end
          mpd_pkg::SET_AXIS_PARAM_CMD: begin
            // volatile store, parameter 4 drives max speed
            if (motor_ok && ax_ok) begin
              st_next.axis[f_m][f_type[AW-1:0]] = f_val;
            end else begin
              st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
            end
          end
          mpd_pkg::GET_AXIS_PARAM_CMD: begin
            if (motor_ok && ax_ok) begin
              st_next.reply_val = rd_val;
              // for this instruction only program execution touches the accumulator
              if (st_reg.prog_mode) begin
                st_next.accu = rd_val;
              end
            end else begin
              st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
            end
          end
          mpd_pkg::SET_GLOBAL_PARAM_CMD: begin
            if (gp_ok) begin
              st_next.glob[f_bank[1:0]][f_type[GW-1:0]] = f_val;
              // bank 0 settings go to nonvolatile store at once
              if (f_bank[1:0] == 2'h0) begin
                st_next.nv_stb = 1'b1;
                st_next.nv_idx = f_type;
                st_next.nv_data = f_val;
              end
            end else begin
              st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
            end
          end
          mpd_pkg::GET_GLOBAL_PARAM_CMD: begin
            // value field of the frame is ignored
            if (gp_ok) begin
              st_next.reply_val = rd_val;
              st_next.accu = rd_val;
            end else begin
              st_next.reply_st = mpd_pkg::ST_BAD_VALUE;
            end
          end
          default: st_next.reply_st = mpd_pkg::ST_BAD_CMD;
        endcase
      end
    end
  end

  // state register, parameters start cleared except the bus address, which starts at 1
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '0;
      st_reg.glob[0][mpd_pkg::GP_BUS_ADDR] <= mpd_pkg::BUS_ADDR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // per motor outputs
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      TARGET_POS[i] = st_reg.axis[i][mpd_pkg::AP_TARGET_POS];
      MAX_SPEED[i] = st_reg.axis[i][mpd_pkg::AP_MAX_SPEED];
    end
  end

  // remaining outputs from flops
  assign PRDATA = st_reg.prdata;
  assign MOVE_STB = st_reg.move_stb;
  assign NV_SAVE_STB = st_reg.nv_stb;
  assign NV_SAVE_IDX = st_reg.nv_idx;
  assign NV_SAVE_DATA = st_reg.nv_data;
  assign BUS_ADDR = bus_addr;

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // a good frame of a given instruction
  sequence s_cmd(logic [7:0] ins);
    go && f_ins == ins && motor_ok;
  endsequence
  // a successful read reply
  sequence s_read_ok;
    st_reg.reply_vld && st_reg.reply_st == mpd_pkg::ST_OK;
  endsequence

  a_rel_move: assert property (
    s_cmd(mpd_pkg::MOVE_TO_POSITION_CMD) and (f_type == mpd_pkg::RELATIVE_MOVE_TYPE)
    |=> TARGET_POS[$past(f_m)] == $past(rel_sum) && MOVE_STB[$past(f_m)])
    else $error("relative move target wrong");
  a_wp_move: assert property (
    s_cmd(mpd_pkg::MOVE_TO_POSITION_CMD) and (f_type == mpd_pkg::STORED_COORDINATE_TYPE)
    |=> MOVE_STB[$past(f_m)] == $past(wp_ok)
        && (!$past(wp_ok) || TARGET_POS[$past(f_m)] == $past(wp_sel)))
    else $error("waypoint move wrong");
  a_max_speed: assert property (
    s_cmd(mpd_pkg::SET_AXIS_PARAM_CMD) and (f_type == 8'h04)
    |=> MAX_SPEED[$past(f_m)] == $past(f_val) ##1 $stable(MAX_SPEED))
    else $error("max speed not written");
  a_gap_prog: assert property (
    s_cmd(mpd_pkg::GET_AXIS_PARAM_CMD) and (ax_ok && st_reg.prog_mode)
    |=> st_reg.accu == $past(rd_val))
    else $error("program read missed accumulator");
  a_gap_direct: assert property (
    s_cmd(mpd_pkg::GET_AXIS_PARAM_CMD) and (!st_reg.prog_mode)
    |=> $stable(st_reg.accu))
    else $error("direct read changed accumulator");
  a_read_reply: assert property (
    go && (f_ins == mpd_pkg::GET_GLOBAL_PARAM_CMD) && gp_ok
    |=> s_read_ok ##0 st_reg.reply_val == $past(rd_val))
    else $error("read reply wrong");
  a_nv_save: assert property (
    go && (f_ins == mpd_pkg::SET_GLOBAL_PARAM_CMD) && gp_ok && f_mb == 8'h00
    |=> NV_SAVE_STB && NV_SAVE_DATA == $past(f_val) ##1 !NV_SAVE_STB)
    else $error("bank 0 write not saved");
  a_ggp_accu: assert property (
    go && (f_ins == mpd_pkg::GET_GLOBAL_PARAM_CMD) && gp_ok
    |=> st_reg.accu == $past(rd_val))
    else $error("global read missed accumulator");
  a_addr_change: assert property (
    go && (f_ins == mpd_pkg::SET_GLOBAL_PARAM_CMD) && f_mb == 8'h00 && f_type == 8'h42
    |=> BUS_ADDR == $past(f_val[7:0]))
    else $error("bus address not updated");
  a_bad_sum: assert property (
    addressed && !fa_sum_ok
    |=> st_reg.reply_st == mpd_pkg::ST_BAD_SUM && MOVE_STB == '0 && !NV_SAVE_STB)
    else $error("bad checksum executed");
endmodule
`default_nettype wire

/* File: test/mpd_host_model.sv */
// host side model: apb master that sends nine-byte command frames
`timescale 1ns/1ps
`default_nettype none
module mpd_host_model (
  input wire logic clk, // module clock
  output logic psel, // apb select
  output logic penable, // apb access phase
  output logic pwrite, // apb direction
  output logic [7:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  logic [31:0] last_rd; // data of last read
  logic last_err; // error flag of last transfer
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // one transfer, request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data inverted so a late sample is seen
    pwdata <= ~d;
  endtask
  // frame bytes in fixed order, value msb first, then checksum
  task automatic send_frame(input logic [7:0] a, i, t, m, input logic [31:0] v,
                            input logic [7:0] bad);
    logic [7:0] f [9];
    logic [7:0] s;
    f[0] = a;
    f[1] = i;
    f[2] = t;
    f[3] = m;
    f[4] = v[31:24];
    f[5] = v[23:16];
    f[6] = v[15:8];
    f[7] = v[7:0];
    s = 8'h00;
    for (int k = 0; k < 8; k++) s = s + f[k];
    f[8] = s + bad;
    for (int k = 0; k < 9; k++) xfer(1'b1, mpd_pkg::REG_FRAME, {24'h000000, f[k]});
  endtask
endmodule
`default_nettype wire

/* File: test/tb_motion_param_command_decoder.sv */
// self-checking bench for the command decoder, frames sent over apb
`timescale 1ns/1ps
`default_nettype none
module tb_motion_param_command_decoder;
  logic sys_clk = 1'b0; // module clock
  logic nrst = 1'b0; // reset, active low
  logic psel, penable, pwrite, pready, pslverr, nv_stb; // apb and save strobe
  logic [7:0] paddr, nv_idx, bus_addr; // address, save index, bus address
  logic [31:0] pwdata, prdata, nv_data, d; // data words
  logic [2:0][31:0] target_pos, max_speed; // per motor outputs
  logic [2:0] move_stb; // move pulses
  int error_cnt = 0; // mismatches
  int total_checks = 0; // comparisons
  int mv_cnt [3] = '{0, 0, 0}; // move pulses seen per motor
  int nv_cnt = 0; // save pulses seen
  // 25 mhz clock
  always #20 sys_clk = ~sys_clk;
  mpd_cmd_decoder dut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TARGET_POS(target_pos), .MAX_SPEED(max_speed),
    .MOVE_STB(move_stb), .NV_SAVE_STB(nv_stb), .NV_SAVE_IDX(nv_idx),
    .NV_SAVE_DATA(nv_data), .BUS_ADDR(bus_addr));
  mpd_host_model host (.clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // count one-cycle pulses
  always @(posedge sys_clk) begin
    for (int k = 0; k < 3; k++) if (move_stb[k] === 1'b1) mv_cnt[k]++;
    if (nv_stb === 1'b1) nv_cnt++;
  end
  // compare a word
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  // compare a flag
  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    host.xfer(1'b0, a, 32'h00000000);
    v = host.last_rd;
  endtask
  // one frame and its reply; code 0 means no reply expected
  task automatic cmd(input logic [7:0] a, i, t, m, input logic [31:0] v,
                     input logic [7:0] bad, code, input logic [31:0] val);
    logic [31:0] s;
    wr(mpd_pkg::REG_STATUS, 32'h00000001);
    host.send_frame(a, i, t, m, v, bad);
    repeat (3) @(posedge sys_clk);
    rd(mpd_pkg::REG_STATUS, s);
    chkb(s[0], code != 8'h00);
    if (code != 8'h00) chk32({24'h000000, s[15:8]}, {24'h000000, code});
    if (code == mpd_pkg::ST_OK && (i == mpd_pkg::GET_AXIS_PARAM_CMD ||
        i == mpd_pkg::GET_GLOBAL_PARAM_CMD)) begin
      rd(mpd_pkg::REG_REPLY, s);
      chk32(s, val);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk32({24'h000000, bus_addr}, 32'h00000001);
    chk32(target_pos[0], 32'h00000000);
    rd(8'h40, d);
    chkb(host.last_err, 1'b1);
    chk32(d, 32'h00000000);
    cmd(8'h01, mpd_pkg::SET_AXIS_PARAM_CMD, 8'h01, 8'h00, 32'd20000, 8'h00, mpd_pkg::ST_OK, 0);
    cmd(8'h01, mpd_pkg::GET_AXIS_PARAM_CMD, 8'h01, 8'h00, 0, 8'h00, mpd_pkg::ST_OK, 32'd20000);
    rd(mpd_pkg::REG_ACCU, d);
    chk32(d, 32'h00000000);
    cmd(8'h01, mpd_pkg::MOVE_TO_POSITION_CMD, mpd_pkg::RELATIVE_MOVE_TYPE, 8'h00, -32'sd10000,
        8'h00, mpd_pkg::ST_OK, 0);
    chk32(target_pos[0], 32'd10000);
    chk32(mv_cnt[0], 32'd1);
    cmd(8'h01, mpd_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h02, 32'd51200, 8'h00, mpd_pkg::ST_OK, 0);
    chk32(max_speed[2], 32'd51200);
    cmd(8'h01, mpd_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h03, 1, 8'h00, mpd_pkg::ST_BAD_VALUE, 0);
    cmd(8'h01, mpd_pkg::MOVE_TO_POSITION_CMD, 8'h00, 8'h00, 1, 8'h00, mpd_pkg::ST_BAD_TYPE, 0);
    cmd(8'h01, 8'h07, 8'h00, 8'h00, 0, 8'h00, mpd_pkg::ST_BAD_CMD, 0);
    cmd(8'h01, mpd_pkg::MOVE_TO_POSITION_CMD, mpd_pkg::STORED_COORDINATE_TYPE, 8'h01, 8, 8'h00,
        mpd_pkg::ST_BAD_VALUE, 0);
    wr(mpd_pkg::REG_WP_IDX, 32'h00000008);
    wr(mpd_pkg::REG_WP_DATA, 32'h00001234);
    cmd(8'h01, mpd_pkg::MOVE_TO_POSITION_CMD, mpd_pkg::STORED_COORDINATE_TYPE, 8'h01, 8, 8'h00,
        mpd_pkg::ST_OK, 0);
    chk32(target_pos[1], 32'h00001234);
    chk32(mv_cnt[1], 32'd1);
    wr(mpd_pkg::REG_CTRL, 32'h00000001);
    cmd(8'h01, mpd_pkg::GET_AXIS_PARAM_CMD, 8'h04, 8'h02, 0, 8'h00, mpd_pkg::ST_OK, 32'd51200);
    rd(mpd_pkg::REG_ACCU, d);
    chk32(d, 32'd51200);
    wr(mpd_pkg::REG_CTRL, 32'h00000000);
    for (int b = 0; b < 4; b++) begin
      cmd(8'h01, mpd_pkg::SET_GLOBAL_PARAM_CMD, 8'h05, b[7:0], 32'd100 + b, 8'h00,
          (b == 1) ? mpd_pkg::ST_BAD_VALUE : mpd_pkg::ST_OK, 0);
    end
    cmd(8'h01, mpd_pkg::GET_GLOBAL_PARAM_CMD, 8'h05, 8'h02, 32'h0000FFFF, 8'h00, mpd_pkg::ST_OK,
        32'd102);
    rd(mpd_pkg::REG_ACCU, d);
    chk32(d, 32'd102);
    chk32(nv_cnt, 32'd1);
    chk32({24'h000000, nv_idx}, 32'h00000005);
    chk32(nv_data, 32'd100);
    // stray byte then resync, so the next frame must start cleanly
    wr(mpd_pkg::REG_FRAME, 32'h00000001);
    wr(mpd_pkg::REG_CTRL, 32'h00000002);
    cmd(8'h01, mpd_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 9, 8'h01, mpd_pkg::ST_BAD_SUM, 0);
    chk32(max_speed[0], 32'h00000000);
    cmd(8'h01, mpd_pkg::SET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 3, 8'h00, mpd_pkg::ST_OK, 0);
    chk32({24'h000000, bus_addr}, 32'h00000003);
    cmd(8'h01, mpd_pkg::GET_AXIS_PARAM_CMD, 8'h04, 8'h02, 0, 8'h00, 8'h00, 0);
    cmd(8'h03, mpd_pkg::GET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 0, 8'h00, mpd_pkg::ST_OK, 3);
    close_out();
  end
  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
